/* File: link_cfg_pkg.sv */
/*
 * Constants for the gigabit link-configuration block: register map, field
 * positions, reset values and ordered-set symbol codes.
 * Assumes a 32-bit APB bus with byte addresses in paddr[7:0].
 */
package link_cfg_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL             = 8'h00;
    localparam logic [7:0]  OFS_STATUS           = 8'h08;
    localparam logic [7:0]  OFS_TX_WORD          = 8'h10;
    localparam logic [7:0]  OFS_RX_WORD          = 8'h14;
    localparam logic [7:0]  OFS_ICR              = 8'h18;

    // Control register fields
    localparam int          CTRL_SET_LINK_UP_BIT = 0;
    localparam int          CTRL_RX_FC_BIT       = 1;
    localparam int          CTRL_TX_FC_BIT       = 2;
    localparam int          CTRL_PHY_MODE_BIT    = 3;
    localparam int          CTRL_WIDTH           = 4;
    localparam logic [3:0]  CTRL_RESET           = 4'h0;

    // Status register fields
    localparam int          STAT_LINK_UP_BIT     = 0;
    localparam int          STAT_NOSIG_BIT       = 1;
    localparam int          STAT_SYNC_BIT        = 2;
    localparam int          STAT_PHY_LINK_BIT    = 3;
    localparam int          STAT_TX_FC_BIT       = 4;
    localparam int          STAT_RX_FC_BIT       = 5;

    // Transmit configuration word register fields
    localparam int          TXW_SEND_CFG_BIT     = 30;
    localparam int          TXW_HW_NEG_BIT       = 31;
    localparam int          ADV_NEXT_PAGE_BIT    = 15;
    localparam int          ADV_ACK_BIT          = 14;
    localparam int          ADV_RF_MSB           = 13;
    localparam int          ADV_RF_LSB           = 12;
    localparam int          ADV_ASYM_PAUSE_BIT   = 8;
    localparam int          ADV_PAUSE_BIT        = 7;
    localparam int          ADV_HALF_DUPLEX_BIT  = 6;
    localparam int          ADV_FULL_DUPLEX_BIT  = 5;
    localparam logic [31:0] TXW_WRITE_MASK       = 32'hc000_ffff;
    localparam logic [31:0] TXW_RESET            = 32'h0000_01a0;

    // Receive configuration word register fields
    localparam int          RXW_CFG_ACTIVE_BIT   = 29;
    localparam int          RXW_SYNC_BIT         = 30;

    // Interrupt cause register fields
    localparam int          ICR_CFG_RX_BIT       = 0;

    // Ordered-set symbols
    localparam logic [7:0]  SYM_COMMA            = 8'hbc;
    localparam logic [7:0]  SYM_CFG1             = 8'hb5;
    localparam logic [7:0]  SYM_CFG2             = 8'h42;
    localparam logic [7:0]  SYM_IDLE             = 8'h50;

    // Synchronised pin order
    localparam int          PIN_NOSIG            = 0;
    localparam int          PIN_PHY_LINK         = 1;
    localparam int          PIN_RX_SYNC          = 2;
    localparam int          PIN_COUNT            = 3;
endpackage

/* File: config_set_tx.sv */
/*
 * Ordered-set generator: idle sets, or configuration sets carrying the
 * advertised word in symbols three and four.
 * Assumes the transceiver takes one symbol per pclk cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module config_set_tx
    import link_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        send_cfg,
    input  wire logic [15:0] word_in,
    output logic      [7:0]  tx_sym,
    output logic             tx_k
);
    logic [1:0]  pos_reg,  pos_next;
    logic        cfg_reg,  cfg_next;
    logic        alt_reg,  alt_next;
    logic [15:0] word_reg, word_next;
    logic [7:0]  sym_reg,  sym_next;
    logic        k_reg,    k_next;

    always_comb begin
        cfg_next  = cfg_reg;
        alt_next  = alt_reg;
        word_next = word_reg;
        if (pos_reg == 2'd0) begin
            cfg_next = send_cfg;
            if (send_cfg) begin
                word_next = word_in;
                alt_next  = ~alt_reg;
            end
        end
        if (cfg_next)
            pos_next = pos_reg + 2'd1;
        else
            pos_next = (pos_reg == 2'd0) ? 2'd1 : 2'd0;
        k_next = (pos_reg == 2'd0);
        unique case (pos_reg)
            2'd0: sym_next = SYM_COMMA;
            2'd1: sym_next = cfg_next ? (alt_next ? SYM_CFG1 : SYM_CFG2) : SYM_IDLE;
            2'd2: sym_next = word_next[7:0];
            2'd3: sym_next = word_next[15:8];
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_reg  <= 2'd0;
            cfg_reg  <= 1'b0;
            alt_reg  <= 1'b0;
            word_reg <= 16'h0000;
            sym_reg  <= SYM_COMMA;
            k_reg    <= 1'b1;
        end else begin
            pos_reg  <= pos_next;
            cfg_reg  <= cfg_next;
            alt_reg  <= alt_next;
            word_reg <= word_next;
            sym_reg  <= sym_next;
            k_reg    <= k_next;
        end
    end

    assign tx_sym = sym_reg;
    assign tx_k   = k_reg;
endmodule // config_set_tx
`default_nettype wire

/* File: config_set_rx.sv */
/*
 * Ordered-set detector: finds configuration sets in the received symbol
 * stream and delivers each carried word with a one-cycle strobe.
 * Assumes the symbol stream is already retimed onto pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module config_set_rx
    import link_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        in_sync,
    input  wire logic [7:0]  rx_sym,
    input  wire logic        rx_k,
    output logic             cfg_strobe,
    output logic             idle_strobe,
    output logic      [15:0] cfg_word
);
    typedef enum logic [1:0] {HUNT, SECOND, LOW_BYTE, HIGH_BYTE} rx_state_t;

    rx_state_t   state_reg, state_next;
    logic [7:0]  low_reg,   low_next;
    logic [15:0] word_reg,  word_next;
    logic        cfg_reg,   cfg_next;
    logic        idle_reg,  idle_next;

    always_comb begin
        state_next = state_reg;
        low_next   = low_reg;
        word_next  = word_reg;
        cfg_next   = 1'b0;
        idle_next  = 1'b0;
        unique case (state_reg)
            HUNT: begin
                if (rx_k && rx_sym == SYM_COMMA)
                    state_next = SECOND;
            end
            SECOND: begin
                if (!rx_k && (rx_sym == SYM_CFG1 || rx_sym == SYM_CFG2)) begin
                    state_next = LOW_BYTE;
                end else begin
                    state_next = HUNT;
                    idle_next  = !rx_k;
                end
            end
            LOW_BYTE: begin
                low_next   = rx_sym;
                state_next = rx_k ? HUNT : HIGH_BYTE;
            end
            HIGH_BYTE: begin
                state_next = HUNT;
                if (!rx_k) begin
                    word_next = {rx_sym, low_reg};
                    cfg_next  = 1'b1;
                end
            end
        endcase
        if (!in_sync) begin
            state_next = HUNT;
            cfg_next   = 1'b0;
            idle_next  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HUNT;
            low_reg   <= 8'h00;
            word_reg  <= 16'h0000;
            cfg_reg   <= 1'b0;
            idle_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            low_reg   <= low_next;
            word_reg  <= word_next;
            cfg_reg   <= cfg_next;
            idle_reg  <= idle_next;
        end
    end

    assign cfg_strobe  = cfg_reg;
    assign idle_strobe = idle_reg;
    assign cfg_word    = word_reg;
endmodule // config_set_rx
`default_nettype wire

/* File: gigabit_link_config_control.sv */
/*
 * Link-configuration control of a gigabit MAC: APB register file, forced
 * link-up, software negotiation through configuration ordered sets, and
 * acceptance of an internal PHY's link indication.
 * Assumes rx_sym/rx_k are already retimed onto pclk by the transceiver;
 * loss-of-signal, PHY link and receive-sync pins are asynchronous.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gigabit_link_config_control
    import link_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        loss_of_signal_in,
    input  wire logic        phy_link_in,
    input  wire logic        rx_sync_in,
    input  wire logic [7:0]  rx_sym,
    input  wire logic        rx_k,
    output logic      [7:0]  tx_sym,
    output logic             tx_k,
    output logic             link_up_n,
    output logic             mac_data_enable,
    output logic             tx_flow_ctrl_out,
    output logic             rx_flow_ctrl_out
);
    function automatic logic reg_known(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_TX_WORD) ||
               (a == OFS_RX_WORD) || (a == OFS_ICR);
    endfunction

    // Two-stage synchronisers for the asynchronous pins
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;

    assign pin_raw = {rx_sync_in, phy_link_in, loss_of_signal_in};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    logic nosig_sync;
    logic phy_link_sync;
    logic rx_sync;

    assign nosig_sync    = pin_sync_reg[PIN_NOSIG];
    assign phy_link_sync = pin_sync_reg[PIN_PHY_LINK];
    assign rx_sync       = pin_sync_reg[PIN_RX_SYNC];

    // Registers
    logic [CTRL_WIDTH-1:0] ctrl_reg,          ctrl_next;
    logic [31:0]           txw_reg,           txw_next;
    logic [15:0]           rxw_word_reg,      rxw_word_next;
    logic                  rx_cfg_active_reg, rx_cfg_active_next;
    logic                  config_received_irq_reg, config_received_irq_next;
    logic                  sync_prev_reg,     sync_prev_next;
    logic                  link_up_reg,       link_up_next;
    logic                  tx_fc_reg,         tx_fc_next;
    logic                  rx_fc_reg,         rx_fc_next;
    logic [31:0]           prdata_reg,        prdata_next;

    logic        set_link_up;
    logic        rx_flow_ctrl_enable;
    logic        tx_flow_ctrl_enable;
    logic        phy_mode;
    logic        hw_negotiation_enable;
    logic        send_config_sets_bit;
    logic [15:0] advertised_word_field;
    logic        asym_pause_adv;
    logic        cfg_strobe;
    logic        idle_strobe;
    logic [15:0] cfg_word;
    logic        wr_access;
    logic        sync_lost;
    logic [31:0] read_mux;

    assign set_link_up           = ctrl_reg[CTRL_SET_LINK_UP_BIT];
    assign rx_flow_ctrl_enable   = ctrl_reg[CTRL_RX_FC_BIT];
    assign tx_flow_ctrl_enable   = ctrl_reg[CTRL_TX_FC_BIT];
    assign phy_mode              = ctrl_reg[CTRL_PHY_MODE_BIT];
    assign hw_negotiation_enable = txw_reg[TXW_HW_NEG_BIT];
    assign send_config_sets_bit  = txw_reg[TXW_SEND_CFG_BIT];
    assign advertised_word_field = txw_reg[15:0];
    assign asym_pause_adv        = advertised_word_field[ADV_ASYM_PAUSE_BIT];

    assign wr_access = psel && penable && pwrite;
    assign sync_lost = sync_prev_reg && !rx_sync;

    // Configuration sets go out while software holds the send bit and PHY mode is off
    config_set_tx u_tx (
        .pclk     (pclk),
        .presetn  (presetn),
        .send_cfg (send_config_sets_bit && !phy_mode),
        .word_in  (advertised_word_field),
        .tx_sym   (tx_sym),
        .tx_k     (tx_k)
    );

    config_set_rx u_rx (
        .pclk        (pclk),
        .presetn     (presetn),
        .in_sync     (rx_sync),
        .rx_sym      (rx_sym),
        .rx_k        (rx_k),
        .cfg_strobe  (cfg_strobe),
        .idle_strobe (idle_strobe),
        .cfg_word    (cfg_word)
    );

    always_comb begin
        ctrl_next      = ctrl_reg;
        txw_next       = txw_reg;
        rxw_word_next  = rxw_word_reg;
        sync_prev_next = rx_sync;
        if (wr_access && paddr == OFS_CTRL)
            ctrl_next = pwdata[CTRL_WIDTH-1:0];
        // Word bits keep their base-page positions as written
        if (wr_access && paddr == OFS_TX_WORD)
            txw_next = pwdata & TXW_WRITE_MASK;
        // Sync loss withdraws the acknowledge the word was carrying
        if (sync_lost)
            txw_next[ADV_ACK_BIT] = 1'b0;
        if (cfg_strobe)
            rxw_word_next = cfg_word;

        // Partner sending configuration sets; set wins over clear
        rx_cfg_active_next = rx_cfg_active_reg;
        if (idle_strobe || !rx_sync)
            rx_cfg_active_next = 1'b0;
        if (cfg_strobe)
            rx_cfg_active_next = 1'b1;
        config_received_irq_next = config_received_irq_reg;
        if (wr_access && paddr == OFS_ICR && pwdata[ICR_CFG_RX_BIT])
            config_received_irq_next = 1'b0;
        if (cfg_strobe)
            config_received_irq_next = 1'b1;

        if (phy_mode)
            link_up_next = set_link_up && phy_link_sync;
        else
            link_up_next = set_link_up && !hw_negotiation_enable && !nosig_sync;

        rx_fc_next = rx_flow_ctrl_enable;
        tx_fc_next = asym_pause_adv ? tx_flow_ctrl_enable : rx_flow_ctrl_enable;
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: read_mux[CTRL_WIDTH-1:0] = ctrl_reg;
            OFS_STATUS: begin
                read_mux[STAT_LINK_UP_BIT]  = link_up_reg;
                read_mux[STAT_NOSIG_BIT]    = nosig_sync && set_link_up;
                read_mux[STAT_SYNC_BIT]     = rx_sync;
                read_mux[STAT_PHY_LINK_BIT] = phy_link_sync && set_link_up;
                read_mux[STAT_TX_FC_BIT]    = tx_fc_reg;
                read_mux[STAT_RX_FC_BIT]    = rx_fc_reg;
            end
            OFS_TX_WORD: read_mux = txw_reg;
            OFS_RX_WORD: begin
                read_mux[15:0]               = rxw_word_reg;
                read_mux[RXW_CFG_ACTIVE_BIT] = rx_cfg_active_reg;
                read_mux[RXW_SYNC_BIT]       = rx_sync;
            end
            OFS_ICR: read_mux[ICR_CFG_RX_BIT] = config_received_irq_reg;
            default: read_mux = 32'h0000_0000;
        endcase
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite)
            prdata_next = read_mux;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg                <= CTRL_RESET;
            txw_reg                 <= TXW_RESET;
            rxw_word_reg            <= 16'h0000;
            rx_cfg_active_reg       <= 1'b0;
            config_received_irq_reg <= 1'b0;
            sync_prev_reg           <= 1'b0;
            link_up_reg             <= 1'b0;
            tx_fc_reg               <= 1'b0;
            rx_fc_reg               <= 1'b0;
            prdata_reg              <= 32'h0000_0000;
        end else begin
            ctrl_reg                <= ctrl_next;
            txw_reg                 <= txw_next;
            rxw_word_reg            <= rxw_word_next;
            rx_cfg_active_reg       <= rx_cfg_active_next;
            config_received_irq_reg <= config_received_irq_next;
            sync_prev_reg           <= sync_prev_next;
            link_up_reg             <= link_up_next;
            tx_fc_reg               <= tx_fc_next;
            rx_fc_reg               <= rx_fc_next;
            prdata_reg              <= prdata_next;
        end
    end

    assign prdata           = prdata_reg;
    assign pready           = 1'b1;
    assign pslverr          = psel && penable && !reg_known(paddr);
    assign link_up_n        = !link_up_reg;
    assign mac_data_enable  = link_up_reg;
    assign tx_flow_ctrl_out = tx_fc_reg;
    assign rx_flow_ctrl_out = rx_fc_reg;
endmodule // gigabit_link_config_control
`default_nettype wire

/* File: link_cfg_properties.sv */
/* Port-level properties of the link-configuration block.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module link_cfg_properties
    import link_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        loss_of_signal_in,
    input  wire logic        phy_link_in,
    input  wire logic [7:0]  tx_sym,
    input  wire logic        tx_k,
    input  wire logic        link_up_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_comma;
        tx_k && tx_sym == SYM_COMMA;
    endsequence

    property p_pready;
        psel && penable |-> pready;
    endproperty
    property p_err_access;
        pslverr |-> psel && penable;
    endproperty
    property p_rdata_hold;
        psel && penable && !pwrite |=> $stable(prdata);
    endproperty
    property p_los_down;
        (loss_of_signal_in && !phy_link_in) [*4] |-> link_up_n;
    endproperty
    property p_link_cause;
        $fell(link_up_n) |-> !$past(loss_of_signal_in, 3) || $past(phy_link_in, 3);
    endproperty
    property p_cfg_shape;
        s_comma ##1 (tx_sym == SYM_CFG1 || tx_sym == SYM_CFG2) |=> !tx_k ##1 !tx_k ##1 s_comma;
    endproperty
    property p_cfg_alternate;
        s_comma ##1 (tx_sym == SYM_CFG1) ##3 s_comma |=> tx_sym != SYM_CFG1;
    endproperty
    property p_idle_set;
        s_comma ##1 (!tx_k && tx_sym == SYM_IDLE) |=> s_comma;
    endproperty
    property p_k_comma;
        tx_k |-> tx_sym == SYM_COMMA;
    endproperty

    a_pready: assert property (p_pready)
        else $error("pready low in access phase");
    a_err_access: assert property (p_err_access)
        else $error("pslverr outside access phase");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed after access");
    a_los_down: assert property (p_los_down)
        else $error("link up while signal lost");
    a_link_cause: assert property (p_link_cause)
        else $error("link came up without valid signal");
    a_cfg_shape: assert property (p_cfg_shape)
        else $error("configuration set malformed");
    a_cfg_alternate: assert property (p_cfg_alternate)
        else $error("configuration sets do not alternate");
    a_idle_set: assert property (p_idle_set)
        else $error("idle set malformed");
    a_k_comma: assert property (p_k_comma)
        else $error("control symbol other than comma");

    c_cfg: cover property (s_comma ##1 tx_sym == SYM_CFG2);
    c_link: cover property ($fell(link_up_n));
    c_err: cover property (pslverr);
endmodule // link_cfg_properties

bind gigabit_link_config_control link_cfg_properties link_cfg_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .loss_of_signal_in(loss_of_signal_in),
    .phy_link_in(phy_link_in), .tx_sym(tx_sym), .tx_k(tx_k), .link_up_n(link_up_n));
`default_nettype wire

/* File: link_partner_model.sv */
/* Link partner: sends idle or configuration sets, decodes the block's sets.
   Assumes one symbol per pclk on both directions. */
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
    import link_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  tx_sym,
    input  wire logic        tx_k,
    input  wire logic        send_cfg,
    input  wire logic [15:0] adv_word,
    output logic      [7:0]  rx_sym,
    output logic             rx_k,
    output logic      [15:0] seen_word,
    output logic      [31:0] seen_sets
);
    logic [1:0]  ph;
    logic [1:0]  rph;
    logic        alt;
    logic        cfg_now;
    logic [15:0] w_now;
    logic [7:0]  lo;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph        <= 2'd0;
            rph       <= 2'd0;
            alt       <= 1'b0;
            cfg_now   <= 1'b0;
            w_now     <= 16'h0000;
            lo        <= 8'h00;
            rx_sym    <= SYM_IDLE;
            rx_k      <= 1'b0;
            seen_word <= 16'h0000;
            seen_sets <= 32'h0;
        end else begin
            ph <= ph + 2'd1;
            // Sets are never cut: the choice is made at the set boundary
            case (ph)
                2'd0: begin
                    cfg_now <= send_cfg;
                    w_now   <= adv_word;
                    rx_sym  <= SYM_COMMA;
                    rx_k    <= 1'b1;
                end
                2'd1: begin
                    rx_sym <= !cfg_now ? SYM_IDLE : (alt ? SYM_CFG2 : SYM_CFG1);
                    rx_k   <= 1'b0;
                    alt    <= alt ^ cfg_now;
                end
                2'd2: begin
                    rx_sym <= cfg_now ? w_now[7:0] : SYM_COMMA;
                    rx_k   <= !cfg_now;
                end
                default: begin
                    rx_sym <= cfg_now ? w_now[15:8] : SYM_IDLE;
                    rx_k   <= 1'b0;
                end
            endcase
            case (rph)
                2'd0: rph <= (tx_k && tx_sym == SYM_COMMA) ? 2'd1 : 2'd0;
                2'd1: rph <= (!tx_k && (tx_sym == SYM_CFG1 || tx_sym == SYM_CFG2)) ? 2'd2 : 2'd0;
                2'd2: begin
                    lo  <= tx_sym;
                    rph <= 2'd3;
                end
                default: begin
                    seen_word <= {tx_sym, lo};
                    seen_sets <= seen_sets + 32'h1;
                    rph       <= 2'd0;
                end
            endcase
        end
    end
endmodule // link_partner_model
`default_nettype wire

/* File: gigabit_link_config_control_tb.sv */
/* Self-checking bench: APB master, partner model, forced link, PHY mode and flow control.
   Assumes the bound property checker and the partner model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module gigabit_link_config_control_tb;
    import link_cfg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, tx_sym, rx_sym;
    logic [31:0] pwdata, prdata, rd, lfsr, n0, seen_sets;
    logic        nosig, sync, phy_link, tx_k, rx_k, link_up_n, mde, tx_fc, rx_fc, p_send;
    logic [15:0] p_word, seen_word, w;
    int          n_errors, check_count, k;
    logic [15:0] corner [5] = '{16'h8000, 16'h0100, 16'h0080, 16'h0040, 16'h0020};

    gigabit_link_config_control gigabit_link_config_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loss_of_signal_in(nosig), .phy_link_in(phy_link), .rx_sync_in(sync), .rx_sym(rx_sym),
        .rx_k(rx_k), .tx_sym(tx_sym), .tx_k(tx_k), .link_up_n(link_up_n), .mac_data_enable(mde),
        .tx_flow_ctrl_out(tx_fc), .rx_flow_ctrl_out(rx_fc));
    link_partner_model link_partner_model_i (
        .pclk(pclk), .presetn(presetn), .tx_sym(tx_sym), .tx_k(tx_k), .send_cfg(p_send),
        .adv_word(p_word), .rx_sym(rx_sym), .rx_k(rx_k), .seen_word(seen_word), .seen_sets(seen_sets));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic exp_tx(input int a, input int f);
        return a[0] ? f[1] : f[0];
    endfunction

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t mismatch got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, p_send, p_word} = '0;
        {nosig, phy_link, sync} = 3'b001;
        lfsr = 32'd85137;
        tick(4);
        presetn <= 1'b1;
        apb(0, OFS_TX_WORD, 0);
        check(rd, TXW_RESET);
        apb(0, OFS_CTRL, 0);
        check(rd, {28'h0, CTRL_RESET});
        apb(0, 8'h40, 0);
        check(rd, 0);
        check(err, 1);
        check(seen_sets, 0);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_step(lfsr);
            w = (i < 5) ? corner[i] : lfsr[15:0] & 16'hb1e0;
            apb(1, OFS_TX_WORD, {16'h4000, w});
            n0 = seen_sets;
            k = 0;
            while (seen_sets < n0 + 3 && k < 100) begin
                tick(1);
                k++;
            end
            check(seen_word, w);
            apb(0, OFS_TX_WORD, 0);
            check(rd, {16'h4000, w});
        end
        apb(1, OFS_TX_WORD, {16'h0000, w});
        tick(12);
        n0 = seen_sets;
        tick(20);
        check(seen_sets, n0);
        lfsr = lfsr_step(lfsr);
        p_word <= lfsr[15:0];
        p_send <= 1'b1;
        tick(20);
        apb(0, OFS_RX_WORD, 0);
        check({rd[29], rd[15:0]}, {1'b1, p_word});
        p_send <= 1'b0;
        tick(12);
        apb(0, OFS_ICR, 0);
        check(rd[0], 1'b1);
        apb(1, OFS_ICR, 32'h1);
        apb(0, OFS_ICR, 0);
        check(rd[0], 1'b0);
        apb(1, OFS_TX_WORD, 32'h0000_4020);
        sync <= 1'b0;
        tick(4);
        apb(0, OFS_TX_WORD, 0);
        sync <= 1'b1;
        check(rd, 32'h0000_0020);
        nosig <= 1'b1;
        apb(1, OFS_CTRL, 32'h1);
        tick(6);
        check(link_up_n, 1'b1);
        nosig <= 1'b0;
        tick(6);
        check({link_up_n, mde}, 2'b01);
        apb(0, OFS_STATUS, 0);
        check(rd[0], 1'b1);
        apb(1, OFS_TX_WORD, 32'h8000_0000);
        tick(6);
        check(link_up_n, 1'b1);
        apb(1, OFS_TX_WORD, 32'h0);
        for (int a = 0; a < 2; a++)
            for (int f = 0; f < 4; f++) begin
                apb(1, OFS_TX_WORD, {23'h0, a[0], 8'h0});
                apb(1, OFS_CTRL, {29'h0, f[1:0], 1'b1});
                tick(3);
                check({tx_fc, rx_fc}, {exp_tx(a, f), f[0]});
            end
        phy_link <= 1'b1;
        nosig    <= 1'b1;
        apb(1, OFS_CTRL, 32'h8);
        tick(6);
        check({link_up_n, mde}, 2'b10);
        apb(1, OFS_CTRL, 32'h9);
        tick(6);
        check({link_up_n, mde}, 2'b01);
        phy_link <= 1'b0;
        tick(6);
        check(link_up_n, 1'b1);
        finish_test();
    end
endmodule // gigabit_link_config_control_tb
`default_nettype wire
